// >>> hdl/rafvt_pkg.sv
package rafvt_pkg;

  // ==========================================================
  // Bus and register map
  // ==========================================================
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 32;
  localparam logic [15:0] OFF_STA_LO  = 16'h0700;
  localparam logic [15:0] OFF_STA_HI  = 16'h0704;
  localparam logic [15:0] OFF_FSEL    = 16'h0708;
  localparam logic [15:0] OFF_FLT_LO  = 16'h0710;
  localparam logic [15:0] OFF_FLT_HI  = 16'h0714;
  localparam logic [15:0] TX_TBL_BASE = 16'h4000;
  localparam logic [15:0] RX_TBL_BASE = 16'h8000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================
  // Reset values and field positions
  // ==========================================================
  localparam logic [31:0] STA_LO_RST  = 32'hFFFFFFFF;
  localparam logic [15:0] STA_HI_RST  = 16'hFFFF;
  localparam logic [47:0] FLT_RST     = 48'hFFFFFFFFFFFF;
  localparam logic        PROMISC_RST = 1'b1;
  localparam logic [7:0]  IDX_RST     = 8'h00;
  localparam int unsigned PROMISC_BIT = 31;
  localparam int unsigned IDX_W       = 8;
  localparam int unsigned FLT_NUM     = 4;
  localparam logic [7:0]  FLT_LIMIT   = 8'h04;
  localparam int unsigned DA_BYTES    = 6;
  localparam logic [2:0]  DA_LAST     = 3'h5;

  // ==========================================================
  // VLAN tables
  // ==========================================================
  localparam int unsigned TBL_IDX_W   = 12;
  localparam int unsigned TBL_DEPTH   = 4096;
  localparam int unsigned ENT_W       = 14;
  localparam int unsigned VLAN_TAG_BIT   = 0;
  localparam int unsigned VLAN_STRIP_BIT = 1;
  localparam int unsigned VLAN_TRANS_LSB = 2;
  localparam int unsigned VLAN_TRANS_W   = 12;

  // Bits that exist for a given set of built functions
  function automatic logic [ENT_W-1:0] vlan_mask(
    input logic tag_en,
    input logic strip_en,
    input logic trans_en
  );
    logic [ENT_W-1:0] m;
    m = '0;
    m[VLAN_TAG_BIT] = tag_en;
    m[VLAN_STRIP_BIT] = strip_en;
    m[VLAN_TRANS_LSB +: VLAN_TRANS_W] = {VLAN_TRANS_W{trans_en}};
    return m;
  endfunction

  typedef enum logic [0:0] {
    RX_IDLE    = 1'b0,
    RX_COLLECT = 1'b1
  } rafvt_rx_e;

  typedef struct packed {
    logic [47:0]         station;
    logic                promisc;
    logic [7:0]          index;
    logic [3:0][47:0]    filt;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rd_pend;
    logic                rd_tbl;
    logic                rd_rx;
    logic [15:0]         rd_addr;
    logic [31:0]         rd_reg;
    logic [1:0]          rd_resp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    rafvt_rx_e           rx_state;
    logic [2:0]          byte_cnt;
    logic [47:0]         da;
    logic                dec_valid;
    logic                accept;
  } rafvt_state_s;

  typedef struct packed {
    logic [ENT_W-1:0] bus_q;
    logic [ENT_W-1:0] look_q;
  } rafvt_mem_s;

endpackage

// >>> hdl/rafvt_vlan_mem.sv
`timescale 1ns/100ps
module rafvt_vlan_mem #(
  parameter logic [rafvt_pkg::ENT_W-1:0] MASK = '1
) (
  input  wire logic                           clk_in,
  input  wire logic                           rst_in,
  input  wire logic                           wr_en_in,
  input  wire logic [rafvt_pkg::TBL_IDX_W-1:0] wr_addr_in,
  input  wire logic [rafvt_pkg::ENT_W-1:0]     wr_data_in,
  input  wire logic [rafvt_pkg::ENT_W-1:0]     wr_bits_in,
  input  wire logic [rafvt_pkg::TBL_IDX_W-1:0] bus_addr_in,
  output logic      [rafvt_pkg::ENT_W-1:0]     bus_data_out,
  input  wire logic [rafvt_pkg::TBL_IDX_W-1:0] look_addr_in,
  output logic      [rafvt_pkg::ENT_W-1:0]     look_data_out
);
  import rafvt_pkg::*;

  logic [ENT_W-1:0] mem [0:TBL_DEPTH-1];
  rafvt_mem_s       st;
  rafvt_mem_s       next_st;

  // ==========================================================
  // Registered read ports, absent bits read as zero
  // ==========================================================
  always_comb begin
    next_st.bus_q  = mem[bus_addr_in] & MASK;
    next_st.look_q = mem[look_addr_in] & MASK;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Bit-enabled write, absent bits never stored
  // ==========================================================
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      for (int i = 0; i < ENT_W; i++) begin
        if (wr_bits_in[i] && MASK[i]) begin
          mem[wr_addr_in][i] <= wr_data_in[i];
        end
      end
    end
  end

  assign bus_data_out  = st.bus_q;
  assign look_data_out = st.look_q;

endmodule

// >>> hdl/rafvt_regs.sv
// Operation
// - Station address is word 0 bits 31-0 plus word 1 low half bits 47-32.
// - Stored station address is compared with each received destination.
// - First wire byte sits in the lowest byte of the address pair.
// - Promiscuous bit 31 accepts all addresses; resets to one.
// - Index bits 7-0 pick filter 0 to 3 for indirect access.
// - Index holds its value until software writes it again.
// - Filter entry holds 48 bits: low word 31-0, high word bits 15-0.
// - Filters match any address type, unicast, multicast or broadcast.
// - Unused upper bits of index and high words read zero.
// - Transmit VLAN table, 4K word entries from 0x4000.
// - Receive VLAN table, 4K word entries from 0x8000.
// - Entry holds 12-bit translation plus strip and tag bits.
// - Bits of functions not built ignore writes and read zero.
// - Field positions stay fixed whatever subset is built.
// - Exactly four filter entries, each a six-byte address.
`timescale 1ns/100ps
module rafvt_regs #(
  parameter logic TX_TAG_EN   = 1'b1,
  parameter logic TX_STRIP_EN = 1'b1,
  parameter logic TX_TRANS_EN = 1'b1,
  parameter logic RX_TAG_EN   = 1'b1,
  parameter logic RX_STRIP_EN = 1'b1,
  parameter logic RX_TRANS_EN = 1'b1
) (
  input  wire logic                             clk_in,
  input  wire logic                             rst_in,
  input  wire logic [rafvt_pkg::ADDR_W-1:0]     s_axi_awaddr_in,
  input  wire logic                             s_axi_awvalid_in,
  output logic                                  s_axi_awready_out,
  input  wire logic [rafvt_pkg::DATA_W-1:0]     s_axi_wdata_in,
  input  wire logic [3:0]                       s_axi_wstrb_in,
  input  wire logic                             s_axi_wvalid_in,
  output logic                                  s_axi_wready_out,
  output logic      [1:0]                       s_axi_bresp_out,
  output logic                                  s_axi_bvalid_out,
  input  wire logic                             s_axi_bready_in,
  input  wire logic [rafvt_pkg::ADDR_W-1:0]     s_axi_araddr_in,
  input  wire logic                             s_axi_arvalid_in,
  output logic                                  s_axi_arready_out,
  output logic      [rafvt_pkg::DATA_W-1:0]     s_axi_rdata_out,
  output logic      [1:0]                       s_axi_rresp_out,
  output logic                                  s_axi_rvalid_out,
  input  wire logic                             s_axi_rready_in,
  input  wire logic [7:0]                       rx_byte_in,
  input  wire logic                             rx_byte_valid_in,
  input  wire logic                             rx_frame_start_in,
  output logic                                  rx_decision_valid_out,
  output logic                                  rx_accept_out,
  output logic      [47:0]                      rx_dest_addr_out,
  output logic                                  promiscuous_enable_out,
  output logic      [47:0]                      station_address_out,
  input  wire logic [rafvt_pkg::TBL_IDX_W-1:0]  tx_vlan_id_in,
  output logic      [rafvt_pkg::ENT_W-1:0]      tx_vlan_entry_out,
  input  wire logic [rafvt_pkg::TBL_IDX_W-1:0]  rx_vlan_id_in,
  output logic      [rafvt_pkg::ENT_W-1:0]      rx_vlan_entry_out
);
  import rafvt_pkg::*;
  localparam logic [ENT_W-1:0] TX_MASK =
    vlan_mask(TX_TAG_EN, TX_STRIP_EN, TX_TRANS_EN);
  localparam logic [ENT_W-1:0] RX_MASK =
    vlan_mask(RX_TAG_EN, RX_STRIP_EN, RX_TRANS_EN);
  rafvt_state_s      st;
  rafvt_state_s      next_st;
  logic              wr_go;
  logic              rd_go;
  logic [13:0]       wr_word;
  logic [13:0]       rd_word;
  logic [1:0]        flt_sel;
  logic              flt_ok;
  logic              tx_wr;
  logic              rx_wr;
  logic [ENT_W-1:0]  tx_bus_q;
  logic [ENT_W-1:0]  rx_bus_q;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [31:0] merge32(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction
  function automatic logic [15:0] merge16(
    input logic [15:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = merge32({16'h0000, old_v}, new_v, strb);
    return r[15:0];
  endfunction
  // Destination match against station and every filter entry
  function automatic logic addr_hit(
    input logic [47:0]      da,
    input logic [47:0]      sta,
    input logic [3:0][47:0] flt
  );
    logic h;
    h = (da == sta);
    for (int k = 0; k < FLT_NUM; k++) begin
      h = h | (da == flt[k]);
    end
    return h;
  endfunction

  // ==========================================================
  // Bus handshakes and decode
  // ==========================================================
  assign wr_go    = s_axi_awvalid_in && s_axi_wvalid_in && !st.bvalid;
  assign rd_go    = s_axi_arvalid_in && !st.rd_pend && !st.rvalid;
  assign wr_word  = s_axi_awaddr_in[15:2];
  assign rd_word  = s_axi_araddr_in[15:2];
  assign flt_sel  = st.index[1:0];
  assign flt_ok   = (st.index < FLT_LIMIT);
  assign tx_wr    = wr_go &&
                    (s_axi_awaddr_in[15:14] == TX_TBL_BASE[15:14]);
  assign rx_wr    = wr_go &&
                    (s_axi_awaddr_in[15:14] == RX_TBL_BASE[15:14]);

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_st = st;
    next_st.dec_valid = 1'b0;
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      if (wr_word == OFF_STA_LO[15:2]) begin
        next_st.station[31:0] = merge32(st.station[31:0],
                                        s_axi_wdata_in,
                                        s_axi_wstrb_in);
      end else if (wr_word == OFF_STA_HI[15:2]) begin
        next_st.station[47:32] = merge16(st.station[47:32],
                                         s_axi_wdata_in,
                                         s_axi_wstrb_in);
      end else if (wr_word == OFF_FSEL[15:2]) begin
        if (s_axi_wstrb_in[3]) begin
          next_st.promisc = s_axi_wdata_in[PROMISC_BIT];
        end
        if (s_axi_wstrb_in[0]) begin
          next_st.index = s_axi_wdata_in[IDX_W-1:0];
        end
      end else if (wr_word == OFF_FLT_LO[15:2]) begin
        if (flt_ok) begin
          next_st.filt[flt_sel][31:0] =
            merge32(st.filt[flt_sel][31:0], s_axi_wdata_in,
                    s_axi_wstrb_in);
        end
      end else if (wr_word == OFF_FLT_HI[15:2]) begin
        if (flt_ok) begin
          next_st.filt[flt_sel][47:32] =
            merge16(st.filt[flt_sel][47:32], s_axi_wdata_in,
                    s_axi_wstrb_in);
        end
      end else if (!tx_wr && !rx_wr) begin
        next_st.bresp = RESP_SLVERR;
      end
    end
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
    // Second read cycle: table data is now out of its register
    if (st.rd_pend) begin
      next_st.rd_pend = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rresp   = st.rd_resp;
      if (!st.rd_tbl) begin
        next_st.rdata = st.rd_reg;
      end else if (st.rd_rx) begin
        next_st.rdata = {{(DATA_W-ENT_W){1'b0}}, rx_bus_q};
      end else begin
        next_st.rdata = {{(DATA_W-ENT_W){1'b0}}, tx_bus_q};
      end
    end
    if (rd_go) begin
      next_st.rd_pend = 1'b1;
      next_st.rd_addr = s_axi_araddr_in;
      next_st.rd_tbl  = 1'b0;
      next_st.rd_rx   = 1'b0;
      next_st.rd_reg  = '0;
      next_st.rd_resp = RESP_OKAY;
      if (rd_word == OFF_STA_LO[15:2]) begin
        next_st.rd_reg = st.station[31:0];
      end else if (rd_word == OFF_STA_HI[15:2]) begin
        next_st.rd_reg = {16'h0000, st.station[47:32]};
      end else if (rd_word == OFF_FSEL[15:2]) begin
        next_st.rd_reg = {st.promisc, 23'h000000, st.index};
      end else if (rd_word == OFF_FLT_LO[15:2]) begin
        if (flt_ok) begin
          next_st.rd_reg = st.filt[flt_sel][31:0];
        end
      end else if (rd_word == OFF_FLT_HI[15:2]) begin
        if (flt_ok) begin
          next_st.rd_reg = {16'h0000, st.filt[flt_sel][47:32]};
        end
      end else if (s_axi_araddr_in[15:14] == TX_TBL_BASE[15:14]) begin
        next_st.rd_tbl = 1'b1;
      end else if (s_axi_araddr_in[15:14] == RX_TBL_BASE[15:14]) begin
        next_st.rd_tbl = 1'b1;
        next_st.rd_rx  = 1'b1;
      end else begin
        next_st.rd_resp = RESP_SLVERR;
      end
    end
    // Destination address collector, wire order low byte first
    if (rx_byte_valid_in && rx_frame_start_in) begin
      next_st.da       = {40'h0000000000, rx_byte_in};
      next_st.byte_cnt = 3'h1;
      next_st.rx_state = RX_COLLECT;
    end else if (rx_byte_valid_in) begin
      case (st.rx_state)
        RX_IDLE: next_st.byte_cnt = 3'h0;
        RX_COLLECT: begin
          next_st.da[{st.byte_cnt, 3'b000} +: 8] = rx_byte_in;
          if (st.byte_cnt == DA_LAST) begin
            next_st.rx_state  = RX_IDLE;
            next_st.byte_cnt  = 3'h0;
            next_st.dec_valid = 1'b1;
            next_st.accept    = st.promisc ||
              addr_hit(next_st.da, st.station, st.filt);
          end else begin
            next_st.byte_cnt = st.byte_cnt + 3'h1;
          end
        end
        default: next_st.rx_state = RX_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st          <= '0;
      st.station  <= {STA_HI_RST, STA_LO_RST};
      st.promisc  <= PROMISC_RST;
      st.index    <= IDX_RST;
      st.filt     <= {FLT_NUM{FLT_RST}};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // VLAN tables
  // ==========================================================
  rafvt_vlan_mem #(
    .MASK (TX_MASK)
  ) u_tx_tbl (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .wr_en_in      (tx_wr),
    .wr_addr_in    (s_axi_awaddr_in[13:2]),
    .wr_data_in    (s_axi_wdata_in[ENT_W-1:0]),
    .wr_bits_in    ({{6{s_axi_wstrb_in[1]}}, {8{s_axi_wstrb_in[0]}}}),
    .bus_addr_in   (s_axi_araddr_in[13:2]),
    .bus_data_out  (tx_bus_q),
    .look_addr_in  (tx_vlan_id_in),
    .look_data_out (tx_vlan_entry_out)
  );
  rafvt_vlan_mem #(
    .MASK (RX_MASK)
  ) u_rx_tbl (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .wr_en_in      (rx_wr),
    .wr_addr_in    (s_axi_awaddr_in[13:2]),
    .wr_data_in    (s_axi_wdata_in[ENT_W-1:0]),
    .wr_bits_in    ({{6{s_axi_wstrb_in[1]}}, {8{s_axi_wstrb_in[0]}}}),
    .bus_addr_in   (s_axi_araddr_in[13:2]),
    .bus_data_out  (rx_bus_q),
    .look_addr_in  (rx_vlan_id_in),
    .look_data_out (rx_vlan_entry_out)
  );

  // ==========================================================
  // Outputs
  // ==========================================================
  assign s_axi_awready_out      = wr_go;
  assign s_axi_wready_out       = wr_go;
  assign s_axi_bvalid_out       = st.bvalid;
  assign s_axi_bresp_out        = st.bresp;
  assign s_axi_arready_out      = !st.rd_pend && !st.rvalid;
  assign s_axi_rvalid_out       = st.rvalid;
  assign s_axi_rdata_out        = st.rdata;
  assign s_axi_rresp_out        = st.rresp;
  assign rx_decision_valid_out  = st.dec_valid;
  assign rx_accept_out          = st.accept;
  assign rx_dest_addr_out       = st.da;
  assign promiscuous_enable_out = st.promisc;
  assign station_address_out    = st.station;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_RESET_VALUES: assert property (
    $past(rst_in) |-> st.promisc && st.index == IDX_RST &&
      st.filt == {FLT_NUM{FLT_RST}})
    else $error("bad values after reset");
  AST_PROMISC_ACCEPT: assert property (
    st.rx_state == RX_COLLECT && rx_byte_valid_in && !rx_frame_start_in
      && st.byte_cnt == DA_LAST && st.promisc
      |=> rx_decision_valid_out && rx_accept_out)
    else $error("promiscuous frame not accepted");
  AST_STATION_HI: assert property (
    wr_go && wr_word == OFF_STA_HI[15:2] && s_axi_wstrb_in == 4'hF
      |=> st.station[47:32] == $past(s_axi_wdata_in[15:0]))
    else $error("station high half not stored");
  AST_FLT_WRITE: assert property (
    wr_go && wr_word == OFF_FLT_LO[15:2] && flt_ok && s_axi_wstrb_in == 4'hF
      |=> st.filt[$past(flt_sel)][31:0] == $past(s_axi_wdata_in))
    else $error("filter low word not stored in selected entry");
  AST_FLT_RANGE: assert property (
    wr_go && !flt_ok && wr_word[13:1] == OFF_FLT_LO[15:3] |=> $stable(st.filt))
    else $error("out of range index changed a filter");
  AST_INDEX_HOLD: assert property (
    !(wr_go && wr_word == OFF_FSEL[15:2]) |=> $stable(st.index))
    else $error("filter index changed without a write");
  AST_UPPER_ZERO: assert property (
    st.rvalid && st.rd_addr[15:2] == OFF_FSEL[15:2]
      |-> st.rdata[30:8] == 23'h000000)
    else $error("index register upper bits not zero");
  AST_TBL_MASK: assert property (
    st.rvalid && st.rresp == RESP_OKAY &&
      st.rd_addr[15:14] == TX_TBL_BASE[15:14]
      |-> (st.rdata[ENT_W-1:0] & ~TX_MASK) == '0 &&
          st.rdata[DATA_W-1:ENT_W] == '0)
    else $error("absent table bits read nonzero");
  AST_BYTE_ORDER: assert property (
    rx_byte_valid_in && rx_frame_start_in
      |=> st.da[7:0] == $past(rx_byte_in) && st.byte_cnt == 3'h1)
    else $error("first wire byte not in lowest position");
  AST_STATION_HIT: assert property (
    st.dec_valid && $stable(st.station) && st.da == st.station
      |-> st.accept)
    else $error("station address match not accepted");
  AST_REJECT: assert property (
    st.dec_valid && !st.promisc && $stable(st.promisc) &&
      $stable(st.station) && $stable(st.filt) &&
      st.da != st.station && st.da != st.filt[0] &&
      st.da != st.filt[1] && st.da != st.filt[2] && st.da != st.filt[3]
      |-> !st.accept)
    else $error("unmatched frame accepted");
  AST_RD_LAT: assert property (
    rd_go |=> ##1 st.rvalid)
    else $error("read answer late");
  COV_PROMISC: cover property (st.dec_valid && st.promisc && st.accept);
  COV_FILTER_HIT: cover property (
    st.dec_valid && !st.promisc && st.accept && st.da != st.station);
  COV_REJECT: cover property (st.dec_valid && !st.accept);
  COV_TBL_READ: cover property (
    st.rvalid && st.rd_addr[15:14] == RX_TBL_BASE[15:14]);
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import rafvt_pkg::*;
  // ====================================================
  // Stimulus and observed signals
  // ====================================================
  logic        clk_in, rst_in, awv, wv, bready, arv, rready, rx_vld, rx_st;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [7:0]  rx_byte;
  logic [11:0] tx_id, rx_id;
  logic        awrdy, wrdy, bvalid, arrdy, rvalid, dec, acc, prom;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [47:0] dest, sta;
  logic [13:0] tx_ent, rx_ent;
  int          failures, n_checks, cyc;
  localparam logic [3:0][47:0] FV = {48'h3C2A1B0F9E34, 48'h0000AABBCC02,
                                     48'h0100005E0001, 48'h123456789A10};
  // Receive table built without the tag bit
  rafvt_regs #(.RX_TAG_EN(1'b0)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awrdy),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arrdy), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .rx_byte_in(rx_byte),
    .rx_byte_valid_in(rx_vld), .rx_frame_start_in(rx_st),
    .rx_decision_valid_out(dec), .rx_accept_out(acc),
    .rx_dest_addr_out(dest), .promiscuous_enable_out(prom),
    .station_address_out(sta), .tx_vlan_id_in(tx_id),
    .tx_vlan_entry_out(tx_ent), .rx_vlan_id_in(rx_id),
    .rx_vlan_entry_out(rx_ent));
  // ====================================================
  // Shared tasks
  // ====================================================
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int k;
    @(negedge clk_in);
    awaddr = a;
    wdata = d;
    awv = 1'b1;
    wv = 1'b1;
    #1 chk(awrdy && wrdy, 1'b1);
    @(negedge clk_in);
    chk(awrdy || wrdy, 1'b0);
    awv = 1'b0;
    wv = 1'b0;
    for (k = 0; k < 4 && bvalid !== 1'b1; k++) @(negedge clk_in);
    chk(bvalid, 1'b1);
    chk(bresp, er);
    bready = 1'b1;
    @(negedge clk_in);
    bready = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int k;
    @(negedge clk_in);
    araddr = a;
    arv = 1'b1;
    #1 chk(arrdy, 1'b1);
    @(negedge clk_in);
    chk(arrdy, 1'b0);
    arv = 1'b0;
    for (k = 0; k < 4 && rvalid !== 1'b1; k++) @(negedge clk_in);
    chk(rvalid, 1'b1);
    chk(rdata, d);
    chk(rresp, er);
    rready = 1'b1;
    @(negedge clk_in);
    rready = 1'b0;
  endtask
  task automatic frame(input logic [47:0] da, input logic ea);
    int k;
    for (k = 0; k < 6; k++) begin
      @(negedge clk_in);
      rx_byte = da[8*k +: 8];
      rx_st = (k == 0);
      rx_vld = 1'b1;
    end
    @(negedge clk_in);
    rx_vld = 1'b0;
    rx_st = 1'b0;
    for (k = 0; k < 3 && dec !== 1'b1; k++) @(negedge clk_in);
    chk(dec, 1'b1);
    chk(acc, ea);
    chk(dest, da);
  endtask
  // ====================================================
  // Scenarios
  // ====================================================
  task automatic t_reset();
    chk(prom, 1'b1);
    rd(OFF_STA_LO, 32'hFFFFFFFF, RESP_OKAY);
    rd(OFF_STA_HI, 32'h0000FFFF, RESP_OKAY);
    rd(OFF_FSEL, 32'h80000000, RESP_OKAY);
    rd(OFF_FLT_LO, 32'hFFFFFFFF, RESP_OKAY);
    rd(OFF_FLT_HI, 32'h0000FFFF, RESP_OKAY);
    frame(48'h0A0B0C0D0E10, 1'b1);
  endtask
  task automatic t_station();
    wr(OFF_STA_LO, 32'h44332211, RESP_OKAY);
    wr(OFF_STA_HI, 32'hABCD6655, RESP_OKAY);
    rd(OFF_STA_HI, 32'h00006655, RESP_OKAY);
    chk(sta, 48'h665544332211);
    wr(OFF_FSEL, 32'h7FFFFF00, RESP_OKAY);
    rd(OFF_FSEL, 32'h00000000, RESP_OKAY);
    chk(prom, 1'b0);
    frame(48'h665544332211, 1'b1);
    frame(48'hFFFFFFFFFFFF, 1'b1);
    frame(48'h665544332212, 1'b0);
  endtask
  task automatic t_filters();
    for (int i = 0; i < 4; i++) begin
      wr(OFF_FSEL, i, RESP_OKAY);
      wr(OFF_FLT_LO, FV[i][31:0], RESP_OKAY);
      wr(OFF_FLT_HI, {16'hFFFF, FV[i][47:32]}, RESP_OKAY);
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFF_FSEL, i, RESP_OKAY);
      rd(OFF_FLT_LO, FV[i][31:0], RESP_OKAY);
      rd(OFF_FLT_LO, FV[i][31:0], RESP_OKAY);
      rd(OFF_FLT_HI, {16'h0000, FV[i][47:32]}, RESP_OKAY);
      frame(FV[i], 1'b1);
    end
    frame(48'hFFFFFFFFFFFF, 1'b0);
    wr(OFF_FSEL, 32'h00000004, RESP_OKAY);
    wr(OFF_FLT_LO, 32'h12345678, RESP_OKAY);
    rd(OFF_FLT_LO, 32'h00000000, RESP_OKAY);
    rd(16'h0600, 32'h00000000, RESP_SLVERR);
    wr(16'h070C, 32'h00000001, RESP_SLVERR);
    wstrb = 4'h8;
    wr(OFF_FSEL, 32'h800000FF, RESP_OKAY);
    wstrb = 4'hF;
    rd(OFF_FSEL, 32'h80000004, RESP_OKAY);
    frame(48'h665544332212, 1'b1);
  endtask
  task automatic t_vlan();
    wr(TX_TBL_BASE + 16'h0014, 32'hFFFFFFFF, RESP_OKAY);
    rd(TX_TBL_BASE + 16'h0014, 32'h00003FFF, RESP_OKAY);
    wr(16'h7FFC, 32'h0000ABCD, RESP_OKAY);
    rd(16'h7FFC, 32'h00002BCD, RESP_OKAY);
    wr(RX_TBL_BASE + 16'h001C, 32'hFFFFFFFF, RESP_OKAY);
    rd(RX_TBL_BASE + 16'h001C, 32'h00003FFE, RESP_OKAY);
    wr(16'hBFFC, 32'h00000007, RESP_OKAY);
    rd(16'hBFFC, 32'h00000006, RESP_OKAY);
    @(negedge clk_in);
    tx_id = 12'h005;
    rx_id = 12'h007;
    @(negedge clk_in);
    chk(tx_ent, 14'h3FFF);
    chk(rx_ent, 14'h3FFE);
  endtask
  // ====================================================
  // Clock, watchdog and main sequence
  // ====================================================
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    {awv, wv, bready, arv, rready, rx_vld, rx_st} = '0;
    {awaddr, araddr, wdata, rx_byte, tx_id, rx_id} = '0;
    wstrb = 4'hF;
    rst_in = 1'b1;
    repeat (10) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    t_reset();
    t_station();
    t_filters();
    t_vlan();
    summarize();
  end
endmodule
